// ===== logic/reset_power_seq.sv
/*
  Reset, fault and power-state sequencer of a processor module, with an
  APB register slave. Assumes pclk at 10 MHz, presetn async active low,
  connector pins asynchronous, watchdog and GPIO reset pulses on pclk.
*/
// Chosen here: the APB interface to the registers and the placing of the registers.
// Operation
// - Battery fault low blocks wakeup; its assertion forces sleep or an abort.
// - A falling software reset input requests a system software reset.
// - Supply fault assertion forces sleep or an unmaskable imprecise abort.
// - Supply fault is ignored for 10 ms after any wakeup.
// - Reset out follows hardware reset, released before first fetch.
// - Reset out also asserted during sleep, watchdog and GPIO resets.
// - Power enable is negated on sleep entry.
// - Hardware reset is level sensitive, aborts the current instruction.
// - After hardware reset release, execution starts at address zero.
// - Low DC indicator means running from external DC.
// - High USB attach indicator means a host is connected.
`timescale 1ns/100ps
`include "rps_defines.svh"
module reset_power_seq #(
  parameter int unsigned SUPPLY_IGNORE_CYCLES = `SUPPLY_TIMER_MS * (`CLK_HZ / 1000)
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Connector pins
  input wire logic hardware_reset_in_n,
  input wire logic software_reset_req_n,
  input wire logic battery_fault_in_n,
  input wire logic supply_fault_in_n,
  input wire logic wakeup_req_n,
  input wire logic external_dc_present_n,
  input wire logic usb_client_attached,
  output logic reset_output_n,
  output logic core_power_enable,
  // On-chip soft reset sources
  input wire logic watchdog_reset,
  input wire logic gpio_reset,
  // Core side
  output logic instr_abort,
  output logic imprecise_abort,
  output logic fetch_start,
  output logic [31:0] boot_address,
  output logic sw_reset_pulse,
  output logic external_dc_powered,
  output logic usb_host_present,
  output logic irq
);
  rps_pkg::core_t q;
  rps_pkg::core_t next_q;
  logic [`SYNC_W-1:0] sync;
  logic timer_busy;

  function automatic logic fell(input logic [`SYNC_W-1:0] prev, input logic [`SYNC_W-1:0] cur, input int idx);
    fell = prev[idx] & ~cur[idx];
  endfunction

  function automatic logic changed(input logic [`SYNC_W-1:0] prev, input logic [`SYNC_W-1:0] cur, input int idx);
    changed = prev[idx] ^ cur[idx];
  endfunction

  // Every pin read below goes through this first
  pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins({usb_client_attached, external_dc_present_n, wakeup_req_n, supply_fault_in_n,
           battery_fault_in_n, software_reset_req_n, hardware_reset_in_n}),
    .levels(sync)
  );

  supply_timer #(
    .CYCLES(SUPPLY_IGNORE_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(q.timer_start),
    .busy(timer_busy)
  );

  // Sequencer, event capture and register access
  always_comb begin
    logic access;
    logic wr;
    logic rd_clear;
    logic sleep_cmd;
    logic hw_low;
    logic batt_ev;
    logic vdd_ev;
    logic [`EV_W-1:0] ev;
    logic [31:0] rdata;
    access = 1'b0;
    wr = 1'b0;
    rd_clear = 1'b0;
    sleep_cmd = 1'b0;
    hw_low = 1'b0;
    batt_ev = 1'b0;
    vdd_ev = 1'b0;
    ev = '0;
    rdata = '0;
    next_q = q;
    next_q.prev = sync;
    next_q.imprecise_abort = 1'b0;
    next_q.instr_abort = 1'b0;
    next_q.fetch_start = 1'b0;
    next_q.sw_reset_pulse = 1'b0;
    next_q.timer_start = 1'b0;

    // Register writes and read-clear land on the access edge only
    access = psel & penable & q.pready;
    wr = access & pwrite;
    if (wr && paddr == `REG_CTRL) begin
      next_q.fault_sleep = pwdata[`CTRL_FAULT_SLEEP];
      sleep_cmd = pwdata[`CTRL_SLEEP_CMD];
    end
    if (wr && paddr == `REG_INT_MASK) begin
      next_q.int_mask = pwdata[`EV_W-1:0];
    end
    rd_clear = access & ~pwrite & (paddr == `REG_INT_STATUS);

    hw_low = ~sync[`IN_HWRST];
    batt_ev = fell(q.prev, sync, `IN_BATT);
    vdd_ev = fell(q.prev, sync, `IN_VDD) & ~timer_busy;

    // State sequence; faults outrank soft resets and commands
    case (q.state)
      rps_pkg::ST_HOLD: begin
        next_q.state = rps_pkg::ST_RELEASE;
      end
      rps_pkg::ST_RELEASE: begin
        next_q.state = rps_pkg::ST_RUN;
        next_q.fetch_start = 1'b1;
        next_q.boot_address = `BOOT_ADDR;
      end
      rps_pkg::ST_RUN: begin
        if (batt_ev || vdd_ev) begin
          ev[`EV_BATT] = batt_ev;
          ev[`EV_VDD] = vdd_ev;
          if (q.fault_sleep) begin
            next_q.state = rps_pkg::ST_SLEEP;
          end else begin
            next_q.imprecise_abort = 1'b1;
          end
        end else if (fell(q.prev, sync, `IN_SWRST)) begin
          ev[`EV_SWRST] = 1'b1;
          next_q.sw_reset_pulse = 1'b1;
          next_q.state = rps_pkg::ST_SOFT;
          next_q.soft_cnt = `SOFT_HOLD_LEN;
        end else if (watchdog_reset || gpio_reset) begin
          ev[`EV_SOFT] = 1'b1;
          next_q.state = rps_pkg::ST_SOFT;
          next_q.soft_cnt = `SOFT_HOLD_LEN;
        end else if (sleep_cmd) begin
          next_q.state = rps_pkg::ST_SLEEP;
        end
      end
      rps_pkg::ST_SOFT: begin
        if (q.soft_cnt == 4'h0) begin
          next_q.state = rps_pkg::ST_RELEASE;
        end else begin
          next_q.soft_cnt = q.soft_cnt - 4'h1;
        end
      end
      rps_pkg::ST_SLEEP: begin
        // A wake edge during a battery fault is dropped, not deferred
        if (fell(q.prev, sync, `IN_WAKE) && sync[`IN_BATT]) begin
          ev[`EV_WAKE] = 1'b1;
          next_q.timer_start = 1'b1;
          next_q.state = rps_pkg::ST_RELEASE;
        end
      end
      default: begin
        next_q.state = rps_pkg::ST_HOLD;
      end
    endcase

    // Hardware reset level overrides the next state and every core pulse; events and register writes still land
    if (hw_low) begin
      next_q.state = rps_pkg::ST_HOLD;
      next_q.imprecise_abort = 1'b0;
      next_q.sw_reset_pulse = 1'b0;
      next_q.timer_start = 1'b0;
      next_q.fetch_start = 1'b0;
      next_q.instr_abort = (q.state == rps_pkg::ST_RUN);
    end

    ev[`EV_DC] = changed(q.prev, sync, `IN_DC);
    ev[`EV_USB] = changed(q.prev, sync, `IN_USB);
    next_q.external_dc_powered = ~sync[`IN_DC];
    next_q.usb_host_present = sync[`IN_USB];

    // Outputs follow the next state so they match the state register
    next_q.reset_output_n = (next_q.state == rps_pkg::ST_RELEASE) ||
                            (next_q.state == rps_pkg::ST_RUN);
    next_q.core_power_enable = (next_q.state != rps_pkg::ST_SLEEP);

    // Clear only the bits the read returned, so an event after setup is kept; set wins
    next_q.int_status = (q.int_status & ~(rd_clear ? q.prdata[`EV_W-1:0] : '0)) | ev;
    next_q.irq = |(next_q.int_status & next_q.int_mask);

    // Answer in the setup cycle so the access phase has no wait state
    case (paddr)
      `REG_CTRL: rdata = {30'h0, 1'b0, q.fault_sleep};
      `REG_STATUS: rdata = {20'h0, timer_busy, q.usb_host_present, q.external_dc_powered,
                            q.core_power_enable, q.reset_output_n, 2'h0, q.state};
      `REG_INT_STATUS: rdata = {25'h0, q.int_status};
      `REG_INT_MASK: rdata = {25'h0, q.int_mask};
      default: rdata = '0;
    endcase
    next_q.pready = psel & ~penable;
    next_q.prdata = (psel & ~penable) ? rdata : q.prdata;
    next_q.pslverr = (psel & ~penable) & ~((paddr == `REG_CTRL) | (paddr == `REG_STATUS) |
                     (paddr == `REG_INT_STATUS) | (paddr == `REG_INT_MASK));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.state <= rps_pkg::ST_HOLD;
      q.prev <= `SYNC_RST;
      q.fault_sleep <= `CTRL_RST;
      q.core_power_enable <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign reset_output_n = q.reset_output_n;
  assign core_power_enable = q.core_power_enable;
  assign instr_abort = q.instr_abort;
  assign imprecise_abort = q.imprecise_abort;
  assign fetch_start = q.fetch_start;
  assign boot_address = q.boot_address;
  assign sw_reset_pulse = q.sw_reset_pulse;
  assign external_dc_powered = q.external_dc_powered;
  assign usb_host_present = q.usb_host_present;
  assign irq = q.irq;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_release;
    q.state == rps_pkg::ST_RELEASE && reset_output_n && sync[`IN_HWRST];
  endsequence
  sequence s_first_fetch;
    fetch_start && boot_address == `BOOT_ADDR && q.state == rps_pkg::ST_RUN;
  endsequence
  sequence s_batt_edge;
    $fell(sync[`IN_BATT]) && sync[`IN_HWRST] && q.state == rps_pkg::ST_RUN;
  endsequence

  wake_blocked_a: assert property ((q.state == rps_pkg::ST_SLEEP && !sync[`IN_BATT] && sync[`IN_HWRST])
    |=> q.state == rps_pkg::ST_SLEEP) else $error("wake taken during battery fault");
  batt_fault_a: assert property (s_batt_edge |=> ($past(q.fault_sleep) || imprecise_abort) and
    (!$past(q.fault_sleep) || (q.state == rps_pkg::ST_SLEEP && !core_power_enable)))
    else $error("battery fault not acted on");
  sw_reset_a: assert property (($fell(sync[`IN_SWRST]) && sync[`IN_HWRST] && sync[`IN_BATT] && !$fell(sync[`IN_VDD])
    && q.state == rps_pkg::ST_RUN) |=> sw_reset_pulse && !reset_output_n ##1 !reset_output_n[*8])
    else $error("software reset edge missed");
  vdd_ignored_a: assert property (($fell(sync[`IN_VDD]) && timer_busy && sync[`IN_BATT] && sync[`IN_HWRST]
    && q.state == rps_pkg::ST_RUN) |=> !imprecise_abort && q.state != rps_pkg::ST_SLEEP)
    else $error("supply fault acted on inside ignore window");
  vdd_fault_a: assert property (($fell(sync[`IN_VDD]) && !timer_busy && sync[`IN_HWRST] && !q.fault_sleep
    && q.state == rps_pkg::ST_RUN) |=> imprecise_abort) else $error("supply fault not raised");
  wake_timer_a: assert property ((q.state == rps_pkg::ST_SLEEP) ##1 (q.state == rps_pkg::ST_RELEASE)
    |=> timer_busy [*8]) else $error("supply timer not started on wake");
  hw_reset_out_a: assert property (!sync[`IN_HWRST] |=> !reset_output_n && !fetch_start)
    else $error("reset out not following hardware reset");
  first_fetch_a: assert property (s_release |=> s_first_fetch)
    else $error("fetch not after reset release");
  sleep_pins_a: assert property (q.state == rps_pkg::ST_SLEEP |-> !reset_output_n && !core_power_enable)
    else $error("sleep without reset out or power off");
  instr_abort_a: assert property (($fell(sync[`IN_HWRST]) && q.state == rps_pkg::ST_RUN) |=> instr_abort)
    else $error("instruction not aborted by hardware reset");
  dc_status_a: assert property ($changed(sync[`IN_DC]) |=> external_dc_powered == !$past(sync[`IN_DC]))
    else $error("dc indicator wrong");
  usb_status_a: assert property ($changed(sync[`IN_USB]) |=> usb_host_present == $past(sync[`IN_USB]))
    else $error("usb indicator wrong");
endmodule // reset_power_seq

// ===== common/rps_defines.svh
/*
  Constants of the reset, fault and power sequencer: offsets, fields,
  reset values and timing counts. Included by the package and the design.
*/
`ifndef RPS_DEFINES_SVH
`define RPS_DEFINES_SVH
// Clock and timing
`define CLK_HZ 10000000
`define SUPPLY_TIMER_MS 10
`define TIMER_W 17
`define SOFT_HOLD_LEN 4'h8
// Synchronised pin vector layout
`define SYNC_W 7
`define IN_HWRST 0
`define IN_SWRST 1
`define IN_BATT 2
`define IN_VDD 3
`define IN_WAKE 4
`define IN_DC 5
`define IN_USB 6
// Hardware reset bit resets asserted, so reset out cannot pulse high on release
`define SYNC_RST 7'h1e
// Register offsets
`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_INT_STATUS 12'h008
`define REG_INT_MASK 12'h00c
// Control fields and reset value
`define CTRL_FAULT_SLEEP 0
`define CTRL_SLEEP_CMD 1
`define CTRL_RST 1'h1
// Event bits, shared by status and mask
`define EV_W 7
`define EV_BATT 0
`define EV_VDD 1
`define EV_SWRST 2
`define EV_WAKE 3
`define EV_DC 4
`define EV_USB 5
`define EV_SOFT 6
`define BOOT_ADDR 32'h0000_0000
`endif

// ===== common/rps_pkg.sv
/*
  Types of the reset, fault and power sequencer.
  Assumes rps_defines.svh on the include path.
*/
`include "rps_defines.svh"
package rps_pkg;
  // One-hot sequencer states
  typedef enum logic [4:0] {
    ST_HOLD = 5'b00001,
    ST_RELEASE = 5'b00010,
    ST_RUN = 5'b00100,
    ST_SOFT = 5'b01000,
    ST_SLEEP = 5'b10000
  } state_t;

  typedef struct packed {
    logic [`SYNC_W-1:0] stage1;
    logic [`SYNC_W-1:0] stage2;
  } sync_t;

  typedef struct packed {
    logic busy;
    logic [`TIMER_W-1:0] count;
  } timer_t;

  typedef struct packed {
    state_t state;
    logic [`SYNC_W-1:0] prev;
    logic [3:0] soft_cnt;
    logic fault_sleep;
    logic [`EV_W-1:0] int_status;
    logic [`EV_W-1:0] int_mask;
    logic irq;
    logic reset_output_n;
    logic core_power_enable;
    logic imprecise_abort;
    logic instr_abort;
    logic fetch_start;
    logic [31:0] boot_address;
    logic sw_reset_pulse;
    logic external_dc_powered;
    logic usb_host_present;
    logic timer_start;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } core_t;
endpackage

// ===== logic/pin_sync.sv
/*
  Two-flop synchroniser for the connector inputs.
  Assumes the pins are asynchronous to pclk; read only the output.
*/
`timescale 1ns/100ps
`include "rps_defines.svh"
module pin_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins in, synchronised levels out
  input wire logic [`SYNC_W-1:0] pins,
  output logic [`SYNC_W-1:0] levels
);
  rps_pkg::sync_t q;
  rps_pkg::sync_t next_q;

  // Second stage is the only reader of the first
  always_comb begin
    next_q.stage1 = pins;
    next_q.stage2 = q.stage1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= {`SYNC_RST, `SYNC_RST};
    end else begin
      q <= next_q;
    end
  end

  assign levels = q.stage2;
endmodule // pin_sync

// ===== logic/supply_timer.sv
/*
  Power supply timer: runs CYCLES clocks after a start pulse.
  Assumes start is a one-cycle pulse from pclk logic.
*/
`timescale 1ns/100ps
`include "rps_defines.svh"
module supply_timer #(
  parameter int unsigned CYCLES = 100000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic start,
  output logic busy
);
  rps_pkg::timer_t q;
  rps_pkg::timer_t next_q;

  // A restart reloads, so back-to-back wakeups extend the window
  always_comb begin
    next_q = q;
    if (start) begin
      next_q.busy = 1'b1;
      next_q.count = `TIMER_W'(CYCLES - 1);
    end else if (q.busy) begin
      if (q.count == '0) begin
        next_q.busy = 1'b0;
      end else begin
        next_q.count = q.count - 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign busy = q.busy;
endmodule // supply_timer

// ===== sim/carrier_model.sv
/*
  Carrier board supply and reset circuit model.
  Assumes the bench calls its tasks; pins are driven after pclk edges.
*/
`timescale 1ns/100ps
module carrier_model #(
  parameter int unsigned PULSE = 10000,
  parameter int unsigned SETTLE = 40
) (
  // Clock
  input wire logic pclk,
  // Pins toward the module
  output logic hardware_reset_in_n,
  output logic battery_fault_in_n,
  output logic supply_fault_in_n
);
  // Reset low from power-up, faults idle high
  initial begin
    hardware_reset_in_n = 1'b0;
    battery_fault_in_n = 1'b1;
    supply_fault_in_n = 1'b1;
  end
  // Reset held until supply and oscillator have settled
  task automatic hw_reset();
    @(posedge pclk);
    hardware_reset_in_n <= 1'b0;
    repeat (SETTLE) @(posedge pclk);
    hardware_reset_in_n <= 1'b1;
  endtask
  // Fault held for the full 1 ms, never shorter
  task automatic fault(input bit vdd);
    @(posedge pclk);
    if (vdd) supply_fault_in_n <= 1'b0;
    else battery_fault_in_n <= 1'b0;
    repeat (PULSE) @(posedge pclk);
    supply_fault_in_n <= 1'b1;
    battery_fault_in_n <= 1'b1;
  endtask
endmodule // carrier_model

// ===== sim/tb_top.sv
/*
  Self-checking bench of the reset, fault and power sequencer.
  Assumes the carrier model on the pins and APB driven from here.
*/
`timescale 1ns/100ps
`include "rps_defines.svh"
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, boot_address;
  logic pready, pslverr, er, hardware_reset_in_n, battery_fault_in_n, supply_fault_in_n;
  logic software_reset_req_n = 1'b1, wakeup_req_n = 1'b1, external_dc_present_n = 1'b1;
  logic usb_client_attached = 1'b0, watchdog_reset = 1'b0, gpio_reset = 1'b0;
  logic reset_output_n, core_power_enable, instr_abort, imprecise_abort, fetch_start;
  logic sw_reset_pulse, external_dc_powered, usb_host_present, irq;
  int fails = 0, num_checks = 0, n_imp = 0, n_sw = 0, n_iab = 0, n_low = 0, b;

  // Short ignore window keeps the run brief
  reset_power_seq #(.SUPPLY_IGNORE_CYCLES(20)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hardware_reset_in_n,
    .software_reset_req_n, .battery_fault_in_n, .supply_fault_in_n, .wakeup_req_n,
    .external_dc_present_n, .usb_client_attached, .reset_output_n, .core_power_enable,
    .watchdog_reset, .gpio_reset, .instr_abort, .imprecise_abort, .fetch_start,
    .boot_address, .sw_reset_pulse, .external_dc_powered, .usb_host_present, .irq);
  carrier_model u_carrier (.pclk, .hardware_reset_in_n, .battery_fault_in_n,
    .supply_fault_in_n);

  // Clock at 10 MHz
  always #50 pclk = ~pclk;
  // Pulse and reset-low counters
  always @(posedge pclk) begin
    n_imp += (imprecise_abort === 1'b1);
    n_sw += (sw_reset_pulse === 1'b1);
    n_iab += (instr_abort === 1'b1);
    n_low += (reset_output_n === 1'b0);
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Request held until pready is sampled high at a rising edge; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(pready, 1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_fetch();
    int n;
    n = 0;
    while (fetch_start !== 1'b1 && n < 500) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(fetch_start, 1);
    chk(reset_output_n, 1);
    chk(boot_address, `BOOT_ADDR);
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask

  task automatic t_boot();
    settle(3);
    chk(reset_output_n, 0);
    u_carrier.hw_reset();
    wait_fetch();
    apb(0, `REG_STATUS, 0);
    chk(rd, 32'h184);
    apb(1, `REG_STATUS, 32'hffffffff);
    apb(0, `REG_STATUS, 0);
    chk(rd, 32'h184);
    apb(0, `REG_CTRL, 0);
    chk(rd, 32'h1);
    apb(0, `REG_INT_MASK, 0);
    chk(rd, 32'h0);
    apb(0, 12'h010, 0);
    chk({rd[30:0], er}, 32'h1);
    apb(0, `REG_INT_STATUS, 0);
    $display("test boot done");
  endtask
  task automatic t_dcusb();
    external_dc_present_n <= 1'b0;
    usb_client_attached <= 1'b1;
    settle(5);
    chk(external_dc_powered, 1);
    chk(usb_host_present, 1);
    chk(irq, 0);
    apb(1, `REG_INT_MASK, 32'h7f);
    settle(2);
    chk(irq, 1);
    apb(0, `REG_INT_STATUS, 0);
    chk(rd & 32'h30, 32'h30);
    settle(2);
    chk(irq, 0);
    $display("test dc usb done");
  endtask
  task automatic t_fault();
    fork
      u_carrier.fault(0);
      begin
        settle(100);
        @(posedge pclk);
        wakeup_req_n <= 1'b0;
        @(posedge pclk);
        wakeup_req_n <= 1'b1;
      end
    join
    chk(core_power_enable, 0);
    chk(reset_output_n, 0);
    chk(irq, 1);
    apb(0, `REG_INT_STATUS, 0);
    chk(rd & 32'h9, 32'h1);
    wakeup_req_n <= 1'b0;
    wait_fetch();
    @(posedge pclk);
    wakeup_req_n <= 1'b1;
    u_carrier.fault(1);
    chk(core_power_enable, 1);
    apb(0, `REG_INT_STATUS, 0);
    chk(rd & 32'h2, 32'h0);
    apb(1, `REG_CTRL, 32'h0);
    b = n_imp;
    u_carrier.fault(1);
    chk(n_imp - b, 1);
    chk(core_power_enable, 1);
    // Sleep by register command, then wake again
    apb(1, `REG_CTRL, 32'h3);
    settle(3);
    chk(core_power_enable, 0);
    chk(reset_output_n, 0);
    @(posedge pclk);
    wakeup_req_n <= 1'b0;
    wait_fetch();
    @(posedge pclk);
    wakeup_req_n <= 1'b1;
    apb(0, `REG_CTRL, 0);
    chk(rd, 32'h1);
    $display("test faults done");
  endtask
  task automatic t_soft();
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      b = n_low;
      if (i == 0) software_reset_req_n <= 1'b0;
      watchdog_reset <= (i == 1);
      gpio_reset <= (i == 2);
      @(posedge pclk);
      watchdog_reset <= 1'b0;
      gpio_reset <= 1'b0;
      wait_fetch();
      @(posedge pclk);
      software_reset_req_n <= 1'b1;
      chk(n_low - b, `SOFT_HOLD_LEN + 1);
    end
    chk(n_sw, 1);
    b = n_iab;
    u_carrier.hw_reset();
    chk(n_iab - b, 1);
    chk(reset_output_n, 0);
    wait_fetch();
    $display("test soft resets done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence after 5 cycles of reset
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_boot();
    t_dcusb();
    t_fault();
    t_soft();
    finish_test();
  end
  // Watchdog well beyond the expected 3 ms
  initial begin
    #6000000;
    fails++;
    finish_test();
  end
endmodule // tb_top
